// File: hdl/lcgs_cell.sv
`timescale 1ns/1ps
module lcgs_cell
	import lcgs_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Configuration
	input  wire logic       en_i,
	input  wire logic [2:0] mode_i,
	input  wire logic       out_inv_i,
	input  wire logic       rise_en_i,
	input  wire logic       fall_en_i,
	// Gates
	input  wire logic [3:0] gate_i,
	// Results
	output logic            out_o,
	output logic            rise_o,
	output logic            fall_o
);
	logic       q_ff;
	logic       g1_ff;
	logic       out_ff;
	logic       rise_ff;
	logic       fall_ff;
	logic       nxt_q;
	logic       nxt_out;
	logic       func;
	lcgs_mode_t mode;

	always_comb begin
		mode  = lcgs_mode_t'(mode_i);
		nxt_q = q_ff;
		func  = 1'b0;
		unique case (mode)
			LCGS_AND_OR:   func = (gate_i[0] & gate_i[1]) | (gate_i[2] & gate_i[3]);
			LCGS_OR_XOR:   func = (gate_i[0] | gate_i[1]) ^ (gate_i[2] | gate_i[3]);
			LCGS_AND4:     func = &gate_i;
			LCGS_SR_LATCH: begin
				if (gate_i[0] | gate_i[1])
					nxt_q = 1'b1;
				else if (gate_i[2] | gate_i[3])
					nxt_q = 1'b0;
				func = nxt_q;
			end
			LCGS_D_FLOP: begin
				// Gate 1 rising edge clocks gate 2 in
				if (gate_i[2])
					nxt_q = 1'b0;
				else if (gate_i[3])
					nxt_q = 1'b1;
				else if (gate_i[0] & ~g1_ff)
					nxt_q = gate_i[1];
				func = nxt_q;
			end
			LCGS_JK_FLOP: begin
				if (gate_i[2])
					nxt_q = 1'b0;
				else if (gate_i[0] & ~g1_ff)
					nxt_q = (gate_i[1] & ~q_ff) | (~gate_i[3] & q_ff);
				func = nxt_q;
			end
			LCGS_D_LATCH: begin
				if (gate_i[2])
					nxt_q = 1'b0;
				else if (gate_i[3])
					nxt_q = 1'b1;
				else if (gate_i[0])
					nxt_q = gate_i[1];
				func = nxt_q;
			end
			LCGS_OR4:      func = |gate_i;
		endcase
		// Disabled cell holds its output low
		nxt_out = en_i & (func ^ out_inv_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_ff    <= 1'b0;
			g1_ff   <= 1'b0;
			out_ff  <= 1'b0;
			rise_ff <= 1'b0;
			fall_ff <= 1'b0;
		end else begin
			q_ff    <= nxt_q;
			g1_ff   <= gate_i[0];
			out_ff  <= nxt_out;
			rise_ff <= rise_en_i & nxt_out & ~out_ff;
			fall_ff <= fall_en_i & ~nxt_out & out_ff;
		end
	end

	assign out_o  = out_ff;
	assign rise_o = rise_ff;
	assign fall_o = fall_ff;
endmodule : lcgs_cell

// File: hdl/lcgs_gate.sv
`timescale 1ns/1ps
module lcgs_gate (
	// Configuration
	input  wire logic [7:0] en_i,
	input  wire logic       inv_i,
	// Data
	input  wire logic [3:0] data_i,
	output logic            gate_o
);
	logic [7:0] sig;

	always_comb begin
		sig = 8'h00;
		for (int k = 0; k < 4; k++) begin
			sig[2*k+1] = data_i[k];
			sig[2*k]   = ~data_i[k];
		end
		// No enable set leaves the OR at zero
		gate_o = (|(en_i & sig)) ^ inv_i;
	end
endmodule : lcgs_gate

// File: hdl/lcgs_pkg.sv
package lcgs_pkg;
	localparam int          NUM_CELLS   = 4;
	localparam int          NUM_GATES   = 4;
	localparam int          NUM_INPUTS  = 4;
	// Register indices inside one cell window
	localparam logic [3:0]  IDX_CTRL    = 4'h0;
	localparam logic [3:0]  IDX_POL     = 4'h1;
	localparam logic [3:0]  IDX_SEL0    = 4'h2;
	localparam logic [3:0]  IDX_SEL3    = 4'h5;
	localparam logic [3:0]  IDX_GLS0    = 4'h6;
	localparam logic [3:0]  IDX_GLS3    = 4'h9;
	// Byte addresses: cell c window at c * 0x40, mirror on its own
	localparam logic [8:0]  OFF_MIRROR  = 9'h100;
	localparam int          ADR_W       = 9;
	// Control register fields
	localparam int          CTRL_EN_BIT   = 7;
	localparam int          CTRL_OUT_BIT  = 5;
	localparam int          CTRL_RISE_BIT = 4;
	localparam int          CTRL_FALL_BIT = 3;
	localparam logic [7:0]  CTRL_WMASK  = 8'h9F;
	// Polarity register fields
	localparam int          POL_OUT_BIT = 7;
	localparam logic [7:0]  POL_WMASK   = 8'h8F;
	// Source select field
	localparam logic [7:0]  SEL_WMASK   = 8'h3F;
	// Values after reset
	localparam logic [7:0]  RST_CTRL    = 8'h00;
	localparam logic [7:0]  RST_POL     = 8'h00;
	localparam logic [5:0]  RST_SEL     = 6'h00;
	localparam logic [7:0]  RST_GLS     = 8'h00;
	localparam logic [31:0] RST_RDATA   = 32'h0000_0000;

	typedef enum logic [2:0] {
		LCGS_AND_OR,
		LCGS_OR_XOR,
		LCGS_AND4,
		LCGS_SR_LATCH,
		LCGS_D_FLOP,
		LCGS_JK_FLOP,
		LCGS_D_LATCH,
		LCGS_OR4
	} lcgs_mode_t;
endpackage : lcgs_pkg

// File: hdl/lcgs_top.sv
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Gate 3 enables: bits 7..0 pick data4 true/inverted down to data1 inverted.
// - Gate 4 uses the same eight-bit enable layout as gate 3.
// - Gate enables are read/write; power-on value undefined, other resets keep them; here every rst_i clears them to zero.
// - Shared read-only mirror shows cell 4..1 outputs on bits 3..0.
// - Mirror bits 7..4 read zero; mirror reads zero right after reset.
// - Control: enable b7, output b5, rise/fall irq enables b4/b3, mode b2:0.
// - Polarity: output invert b7, gate 4..1 invert b3..0, b6..4 unused.
// - Four source selects per cell, six-bit field, top two bits read zero.
module lcgs_top
	import lcgs_pkg::*;
#(
	parameter int SRC_W = 6
) (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Wishbone slave
	input  wire logic                 cyc_i,
	input  wire logic                 stb_i,
	input  wire logic                 we_i,
	input  wire logic [ADR_W-1:0]     adr_i,
	input  wire logic [3:0]           sel_i,
	input  wire logic [31:0]          dat_i,
	output logic      [31:0]          dat_o,
	output logic                      ack_o,
	// Signal sources
	input  wire logic [(1<<SRC_W)-1:0] src_i,
	// Cell results
	output logic      [NUM_CELLS-1:0] cell_out_o,
	output logic      [NUM_CELLS-1:0] cell_rise_o,
	output logic      [NUM_CELLS-1:0] cell_fall_o
);
	logic [7:0]       ctrl_ff     [NUM_CELLS];
	logic [7:0]       pol_ff      [NUM_CELLS];
	logic [SRC_W-1:0] srcsel_ff   [NUM_CELLS][NUM_INPUTS];
	logic [7:0]       gls_ff      [NUM_CELLS][NUM_GATES];
	logic [7:0]       nxt_ctrl    [NUM_CELLS];
	logic [7:0]       nxt_pol     [NUM_CELLS];
	logic [SRC_W-1:0] nxt_srcsel  [NUM_CELLS][NUM_INPUTS];
	logic [7:0]       nxt_gls     [NUM_CELLS][NUM_GATES];
	logic             ack_ff;
	logic [31:0]      rdat_ff;
	logic             nxt_ack;
	logic [31:0]      nxt_rdat;
	logic             access;
	logic             wr;
	logic             in_cells;
	logic [1:0]       cidx;
	logic [3:0]       ridx;
	logic [7:0]       rbyte;
	logic [NUM_GATES-1:0]  gate  [NUM_CELLS];
	logic [NUM_INPUTS-1:0] data  [NUM_CELLS];
	logic [NUM_CELLS-1:0]  cell_out;

	// Bus decode
	always_comb begin
		access   = cyc_i & stb_i & ~ack_ff;
		wr       = access & we_i & sel_i[0];
		in_cells = ~adr_i[8];
		cidx     = adr_i[7:6];
		ridx     = adr_i[5:2];
	end

	// Register writes; only byte lane 0 carries data
	always_comb begin
		nxt_ctrl   = ctrl_ff;
		nxt_pol    = pol_ff;
		nxt_srcsel = srcsel_ff;
		nxt_gls    = gls_ff;
		if (wr && in_cells && adr_i[1:0] == 2'b00) begin
			if (ridx == IDX_CTRL)
				nxt_ctrl[cidx] = dat_i[7:0] & CTRL_WMASK;
			else if (ridx == IDX_POL)
				nxt_pol[cidx] = dat_i[7:0] & POL_WMASK;
			else if (ridx >= IDX_SEL0 && ridx <= IDX_SEL3)
				nxt_srcsel[cidx][2'(ridx - IDX_SEL0)] = dat_i[SRC_W-1:0];
			else if (ridx >= IDX_GLS0 && ridx <= IDX_GLS3)
				nxt_gls[cidx][2'(ridx - IDX_GLS0)] = dat_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int c = 0; c < NUM_CELLS; c++) begin
				ctrl_ff[c] <= RST_CTRL;
				pol_ff[c]  <= RST_POL;
				for (int k = 0; k < NUM_INPUTS; k++)
					srcsel_ff[c][k] <= RST_SEL;
				// Power-on value is free; zero chosen for determinism
				for (int g = 0; g < NUM_GATES; g++)
					gls_ff[c][g] <= RST_GLS;
			end
		end else begin
			ctrl_ff   <= nxt_ctrl;
			pol_ff    <= nxt_pol;
			srcsel_ff <= nxt_srcsel;
			gls_ff    <= nxt_gls;
		end
	end

	// Cell datapath
	genvar c;
	genvar g;
	generate
		for (c = 0; c < NUM_CELLS; c++) begin : g_cell
			always_comb begin
				for (int k = 0; k < NUM_INPUTS; k++)
					data[c][k] = src_i[srcsel_ff[c][k]];
			end
			for (g = 0; g < NUM_GATES; g++) begin : g_gate
				lcgs_gate u_gate (
					.en_i   (gls_ff[c][g]),
					.inv_i  (pol_ff[c][g]),
					.data_i (data[c]),
					.gate_o (gate[c][g])
				);
			end
			lcgs_cell u_cell (
				.clk_i     (clk_i),
				.rst_i     (rst_i),
				.en_i      (ctrl_ff[c][CTRL_EN_BIT]),
				.mode_i    (ctrl_ff[c][2:0]),
				.out_inv_i (pol_ff[c][POL_OUT_BIT]),
				.rise_en_i (ctrl_ff[c][CTRL_RISE_BIT]),
				.fall_en_i (ctrl_ff[c][CTRL_FALL_BIT]),
				.gate_i    (gate[c]),
				.out_o     (cell_out[c]),
				.rise_o    (cell_rise_o[c]),
				.fall_o    (cell_fall_o[c])
			);
		end
	endgenerate

	// Read path; unmapped addresses answer zero
	always_comb begin
		rbyte = 8'h00;
		if (in_cells) begin
			if (ridx == IDX_CTRL) begin
				rbyte = ctrl_ff[cidx];
				rbyte[CTRL_OUT_BIT] = cell_out[cidx];
			end else if (ridx == IDX_POL)
				rbyte = pol_ff[cidx];
			else if (ridx >= IDX_SEL0 && ridx <= IDX_SEL3)
				rbyte = 8'(srcsel_ff[cidx][2'(ridx - IDX_SEL0)]) & SEL_WMASK;
			else if (ridx >= IDX_GLS0 && ridx <= IDX_GLS3)
				rbyte = gls_ff[cidx][2'(ridx - IDX_GLS0)];
		end else if (adr_i == OFF_MIRROR)
			rbyte = {4'h0, cell_out};
		if (adr_i[1:0] != 2'b00)
			rbyte = 8'h00;
		nxt_ack  = access;
		nxt_rdat = (access && !we_i) ? {24'h00_0000, rbyte} : rdat_ff;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff  <= 1'b0;
			rdat_ff <= RST_RDATA;
		end else begin
			ack_ff  <= nxt_ack;
			rdat_ff <= nxt_rdat;
		end
	end

	assign ack_o      = ack_ff;
	assign dat_o      = rdat_ff;
	assign cell_out_o = cell_out;
endmodule : lcgs_top

// File: sim/lcgs_checker.sv
`timescale 1ns/1ps
module lcgs_checker
	import lcgs_pkg::*;
(
	// Clock, reset
	input wire logic                 clk_i,
	input wire logic                 rst_i,
	// Bus
	input wire logic                 cyc_i,
	input wire logic                 stb_i,
	input wire logic                 we_i,
	input wire logic [ADR_W-1:0]     adr_i,
	input wire logic [31:0]          dat_o,
	input wire logic                 ack_o,
	// Cells
	input wire logic [NUM_CELLS-1:0] cell_out_o,
	input wire logic [NUM_CELLS-1:0] cell_rise_o,
	input wire logic [NUM_CELLS-1:0] cell_fall_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
	ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("no ack");
	ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
	read_upper_a: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0)
		else $error("upper read bits set");
	mirror_read_a: assert property (ack_o && !we_i && adr_i == OFF_MIRROR
		|-> dat_o == {28'h0, $past(cell_out_o)}) else $error("mirror mismatch");
	rise_edge_a: assert property ((cell_rise_o & ~(cell_out_o & ~$past(cell_out_o))) == 4'h0)
		else $error("rise pulse without rise");
	fall_edge_a: assert property ((cell_fall_o & ~(~cell_out_o & $past(cell_out_o))) == 4'h0)
		else $error("fall pulse without fall");
	reset_clear_a: assert property (disable iff (1'b0) rst_i |=> !ack_o && cell_out_o == 4'h0)
		else $error("reset left state");
	cover property (ack_o && !we_i && adr_i == OFF_MIRROR);
	cover property (|cell_rise_o);
	cover property (|cell_fall_o);
endmodule : lcgs_checker
bind lcgs_top lcgs_checker chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .cell_out_o(cell_out_o),
	.cell_rise_o(cell_rise_o), .cell_fall_o(cell_fall_o));

// File: sim/test_lcgs_top.sv
`timescale 1ns/1ps
module test_lcgs_top
	import lcgs_pkg::*;
;
	logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, e;
	logic [8:0]  adr_i = 0, b;
	logic [3:0]  sel_i = 0, d, cell_out_o, cell_rise_o, cell_fall_o;
	logic [31:0] dat_i = 0, dat_o;
	logic [63:0] src_i = 0;
	logic [7:0]  q, en;
	logic [5:0]  s [4];
	int          failures = 0, cmp_count = 0, cyc_n = 0, g, seed = 32'h661e;
	lcgs_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.src_i(src_i), .cell_out_o(cell_out_o), .cell_rise_o(cell_rise_o),
		.cell_fall_o(cell_fall_o));
	initial forever #20 clk_i = ~clk_i;
	task print_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	// Hang guard, far above the roughly 2000 cycles needed
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			failures++;
			print_verdict();
		end
	end
	task check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task wb(input logic w, input logic [8:0] a, input logic [7:0] wd);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, wd};
		sel_i <= 4'hF;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb
	function automatic logic gate(input logic [7:0] m, input logic [3:0] x);
		return |(m & {x[3], ~x[3], x[2], ~x[2], x[1], ~x[1], x[0], ~x[0]});
	endfunction : gate
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, OFF_MIRROR, 8'h00);
		check(q, 8'h00);
		wb(1, OFF_MIRROR, 8'hFF);
		wb(0, OFF_MIRROR, 8'h00);
		check(q, 8'h00);
		wb(0, 9'h1FC, 8'h00);
		check(q, 8'h00);
		for (int c = 0; c < 4; c++) begin
			b = 9'(c * 64);
			wb(1, b + 9'h04, 8'hFF);
			wb(0, b + 9'h04, 8'h00);
			check(q, 8'h8F);
			wb(1, b + 9'h14, 8'hFF);
			wb(0, b + 9'h14, 8'h00);
			check(q, 8'h3F);
			for (int t = 0; t < 12; t++) begin
				// Other three gates forced high so AND4 exposes the tested gate
				g = t % 2;
				en = (t < 2) ? 8'hFF : (t < 4) ? 8'h00 : 8'($random(seed));
				for (int k = 0; k < 4; k++) begin
					s[k] = 6'($random(seed));
					wb(1, 9'(b + 8 + 4 * k), {2'b00, s[k]});
				end
				wb(1, b + 9'h04, g ? 8'h07 : 8'h0B);
				wb(1, b + 9'h20, g ? 8'h00 : en);
				wb(1, b + 9'h24, g ? en : 8'h00);
				wb(1, b, 8'h9A);
				wb(0, g ? b + 9'h24 : b + 9'h20, 8'h00);
				check(q, en);
				src_i <= {$random(seed), $random(seed)};
				repeat (3) @(posedge clk_i);
				for (int k = 0; k < 4; k++)
					d[k] = src_i[s[k]];
				e = gate(en, d);
				check({7'h0, cell_out_o[c]}, {7'h0, e});
				// Output settled, so no edge pulse may stand now
				check({4'h0, cell_rise_o | cell_fall_o}, 8'h00);
				wb(0, OFF_MIRROR, 8'h00);
				check({q[7:4], 3'h0, q[c]}, {7'h0, e});
				wb(0, b, 8'h00);
				check(q, 8'h9A | {2'b00, e, 5'h00});
			end
			$display("Cell %0d tests done", c);
		end
		print_verdict();
	end
endmodule : test_lcgs_top
